//--- design/csw_select.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1: Disabled line other than the boot line drives pin from level bit
// R2: Boot line has no level bit
// R3: Reset sets level bit on other lines
// R4: Reset sets enable on boot line
// R5: Reset clears enable on other lines
// R6: Enabled line ignores its level bit
// R7: Access to disabled line ends in error
// R8: Boot line with enable clear stays inactive
// R9: Enabled line asserts select on valid access
// R10: Extra zero: read=write=count, zero gives one
// R11: Extra one: write is count plus one
// R12: Extra seven: write is count plus seven, capped at 63
// R13: Access stretched by decoded wait count
module csw_select (
  input  wire logic              i_clock,     // System clock, 20 MHz
  input  wire logic              i_resetn,    // Async reset, active low
  input  wire logic [3:0]        i_addr,      // Register index
  input  wire logic [31:0]       i_wdata,     // Register write data
  input  wire logic              i_wr,        // Register write strobe
  input  wire logic              i_rd,        // Register read strobe
  output logic      [31:0]       o_rdata,     // Register read data
  input  wire logic              i_acc_valid, // External access request
  input  wire logic [2:0]        i_acc_line,  // Target select line
  input  wire logic              i_acc_write, // Access is a write
  output logic                   o_acc_done,  // Access completed ok
  output logic                   o_acc_error, // Access ended in error
  output logic                   o_busy,      // Access in progress
  output logic [5:0]             o_select_n   // Select pins, active low
);
  localparam int N = csw_pkg::NUM_LINES;

  logic [N-1:0]       enable_q;
  logic [N-1:0]       level_q;
  logic [5:0]         wsc_q [N];
  logic [2:0]         wws_q [N];
  csw_pkg::csw_state_t state_q;
  logic [6:0]         count_q;
  logic [2:0]         line_q;
  logic               write_q;
  logic [N-1:0]       sel_q;
  logic [N-1:0]       pin_q;
  logic [31:0]        rdata_q;
  logic               err_q;
  logic               done_q;
  logic               err_sticky_q;

  // Wait states for one access; the reserved count is clamped to the maximum
  function automatic logic [6:0] wait_states(input logic [5:0] wait_count_field, input logic [2:0] write_extra_wait_field,
                                             input logic is_write);
    logic [6:0] base;
    logic [6:0] sum;
    base = (wait_count_field == 6'h00) ? 7'h01 : {1'b0, wait_count_field};                            // R10
    sum  = {1'b0, wait_count_field} + {4'h0, write_extra_wait_field};
    if (wait_count_field == csw_pkg::WSC_RESERVED) begin
      wait_states = csw_pkg::WAIT_MAX;
    end else if (!is_write || write_extra_wait_field == 3'h0) begin
      wait_states = base;                                                   // R10
    end else if (wait_count_field == 6'h00) begin
      wait_states = {4'h0, write_extra_wait_field};                                            // R11 R12
    end else if (sum > csw_pkg::WAIT_MAX) begin
      wait_states = csw_pkg::WAIT_MAX;
    end else begin
      wait_states = sum;                                                    // R11 R12
    end
  endfunction

  function automatic logic [31:0] ctrl_word(input int idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[csw_pkg::POS_ENABLE] = enable_q[idx];
    w[csw_pkg::POS_LEVEL]  = (idx == csw_pkg::BOOT_LINE) ? 1'b0 : level_q[idx];   // R2
    w[csw_pkg::POS_WSC_HI:csw_pkg::POS_WSC_LO] = wsc_q[idx];
    w[csw_pkg::POS_WWS_HI:csw_pkg::POS_WWS_LO] = wws_q[idx];
    ctrl_word = w;
  endfunction

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      localparam logic EN_RST = (g == csw_pkg::BOOT_LINE) ? csw_pkg::RST_EN_BOOT : csw_pkg::RST_EN_OTHER;
      wire hit = i_wr && (i_addr == csw_pkg::OFS_CTRL_BASE + 4'(g));
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          enable_q[g] <= EN_RST;                                            // R4 R5
          wsc_q[g]    <= csw_pkg::RST_WSC;
          wws_q[g]    <= csw_pkg::RST_WWS;
        end else if (hit) begin
          enable_q[g] <= i_wdata[csw_pkg::POS_ENABLE];
          wsc_q[g]    <= i_wdata[csw_pkg::POS_WSC_HI:csw_pkg::POS_WSC_LO];
          wws_q[g]    <= i_wdata[csw_pkg::POS_WWS_HI:csw_pkg::POS_WWS_LO];
        end
      end
      if (g == csw_pkg::BOOT_LINE) begin : g_boot
        assign level_q[g] = 1'b0;                                           // R2
      end else begin : g_other
        always_ff @(posedge i_clock or negedge i_resetn) begin
          if (!i_resetn) begin
            level_q[g] <= csw_pkg::RST_LVL_OTHER;                           // R3
          end else if (hit) begin
            level_q[g] <= i_wdata[csw_pkg::POS_LEVEL];
          end
        end
      end
      // Pin: enabled lines show the select (active low); disabled lines show
      // the level bit; the boot line parks high (inactive) when disabled
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          pin_q[g] <= 1'b1;
        end else if (enable_q[g]) begin
          pin_q[g] <= !sel_q[g];                                            // R6 R9
        end else if (g == csw_pkg::BOOT_LINE) begin
          pin_q[g] <= 1'b1;                                                 // R8
        end else begin
          pin_q[g] <= level_q[g];                                           // R1
        end
      end
    end
  endgenerate

  assign o_select_n = pin_q;

  // Access sequencer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= csw_pkg::ST_IDLE;
      count_q <= 7'h00;
      line_q  <= 3'h0;
      write_q <= 1'b0;
      sel_q   <= '0;
      err_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      err_q  <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        csw_pkg::ST_IDLE: begin
          if (i_acc_valid) begin
            if (i_acc_line >= 3'(N) || !enable_q[i_acc_line]) begin
              err_q <= 1'b1;                                                // R7
            end else begin
              line_q  <= i_acc_line;
              write_q <= i_acc_write;
              count_q <= wait_states(wsc_q[i_acc_line], wws_q[i_acc_line], i_acc_write);  // R13
              sel_q[i_acc_line] <= 1'b1;                                    // R9
              state_q <= csw_pkg::ST_WAIT;
            end
          end
        end
        csw_pkg::ST_WAIT: begin
          if (count_q <= 7'h01) begin
            state_q <= csw_pkg::ST_DONE;
          end else begin
            count_q <= count_q - 7'h01;                                     // R13
          end
        end
        csw_pkg::ST_DONE: begin
          sel_q   <= '0;
          done_q  <= 1'b1;
          state_q <= csw_pkg::ST_IDLE;
        end
        default: begin
          state_q <= csw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign o_acc_done  = done_q;
  assign o_acc_error = err_q;
  assign o_busy      = (state_q != csw_pkg::ST_IDLE);

  // Status: sticky error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      err_sticky_q <= 1'b0;
    end else if (err_q) begin
      err_sticky_q <= 1'b1;
    end else if (i_wr && i_addr == csw_pkg::OFS_STATUS && i_wdata[0]) begin
      err_sticky_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      if (i_addr < csw_pkg::OFS_CTRL_BASE + 4'(N)) begin
        rdata_q <= ctrl_word(int'(i_addr));
      end else if (i_addr == csw_pkg::OFS_STATUS) begin
        rdata_q <= {26'h0, o_busy, err_sticky_q, line_q, write_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;

  // Checks
  AST_PIN_LEVEL: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (!enable_q[1] && !$past(enable_q[1])) |-> (o_select_n[1] == $past(level_q[1])))  // R1
    else $error("disabled line pin not following level bit");
  AST_BOOT_LEVEL_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_rd && i_addr == 4'h0 |=> o_rdata[1] == 1'b0)                          // R2
    else $error("boot line level bit not reserved");
  AST_RESET_LEVEL: assert property (@(posedge i_clock)
    $rose(i_resetn) |-> level_q[5:1] == 5'h1f)                              // R3
    else $error("level bits not set after reset");
  AST_RESET_BOOT_EN: assert property (@(posedge i_clock)
    $rose(i_resetn) |-> enable_q[0])                                        // R4
    else $error("boot enable not set after reset");
  AST_RESET_OTHER_EN: assert property (@(posedge i_clock)
    $rose(i_resetn) |-> enable_q[5:1] == 5'h00)                             // R5
    else $error("other enables not clear after reset");
  AST_ERR_DISABLED: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_q == csw_pkg::ST_IDLE && i_acc_valid && i_acc_line < 3'h6 && !enable_q[i_acc_line])
    |=> o_acc_error && sel_q == '0)                                         // R7
    else $error("access to disabled line not refused");
  AST_BOOT_INACTIVE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !$past(enable_q[0]) |-> o_select_n[0])                                  // R8
    else $error("disabled boot line not inactive");
  AST_SELECT_ON_ACCESS: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_q == csw_pkg::ST_IDLE && i_acc_valid && i_acc_line == 3'h2 && enable_q[2])
    |=> ##1 (o_select_n[2] == 1'b0 || !enable_q[2]))                        // R9 R6
    else $error("enabled line not selected");
  AST_WAIT_LEN: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_q == csw_pkg::ST_IDLE && i_acc_valid && i_acc_line == 3'h1 && enable_q[1]
     && wsc_q[1] == 6'h00 && wws_q[1] == 3'h7 && i_acc_write)
    |=> (state_q == csw_pkg::ST_WAIT)[*7] ##1 state_q == csw_pkg::ST_DONE)  // R12 R13
    else $error("write wait length wrong for extra seven");
  AST_WAIT_ZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_q == csw_pkg::ST_IDLE && i_acc_valid && i_acc_line == 3'h1 && enable_q[1]
     && wsc_q[1] == 6'h00 && wws_q[1] == 3'h1 && i_acc_write)
    |=> (state_q == csw_pkg::ST_WAIT)[*1] ##1 state_q == csw_pkg::ST_DONE)  // R10 R11
    else $error("zero count write wait wrong for extra one");

  COV_ACCESS_DONE: cover property (@(posedge i_clock) disable iff (!i_resetn) o_acc_done);
  COV_ACCESS_ERR: cover property (@(posedge i_clock) disable iff (!i_resetn) o_acc_error);
  COV_LEVEL_LOW: cover property (@(posedge i_clock) disable iff (!i_resetn) !enable_q[3] && !o_select_n[3]);
  COV_WRITE_DONE: cover property (@(posedge i_clock) disable iff (!i_resetn) o_acc_done && write_q);

  // Sequencer invariants: a single select at a time, held only while busy
  AST_DONE_PULSE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_acc_done |=> !o_acc_done)                                             // R13
    else $error("done pulse longer than one cycle");
  AST_ERR_IDLE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_acc_error |-> !o_busy && sel_q == '0)                                 // R7
    else $error("refused access left sequencer busy");
  AST_WAIT_HAS_SEL: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == csw_pkg::ST_WAIT |-> sel_q != '0)                            // R9
    else $error("waiting without a select");
  AST_IDLE_NO_SEL: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == csw_pkg::ST_IDLE |-> sel_q == '0)                            // R9
    else $error("select held while idle");
  AST_ONE_SEL: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $onehot0(sel_q))                                                        // R9
    else $error("more than one select active");
  AST_COUNT_NONZERO: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == csw_pkg::ST_WAIT |-> count_q != 7'h00)                       // R13
    else $error("wait counter reached zero");
  AST_WAIT_FIVE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_q == csw_pkg::ST_IDLE && i_acc_valid && i_acc_line == 3'h1 && enable_q[1]
     && wsc_q[1] == 6'h05 && wws_q[1] == 3'h0)
    |=> (state_q == csw_pkg::ST_WAIT)[*5] ##1 state_q == csw_pkg::ST_DONE)  // R10 R13
    else $error("wait length wrong for extra zero");
  AST_WAIT_ONE_ONE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_q == csw_pkg::ST_IDLE && i_acc_valid && i_acc_line == 3'h1 && enable_q[1]
     && wsc_q[1] == 6'h01 && wws_q[1] == 3'h1 && i_acc_write)
    |=> (state_q == csw_pkg::ST_WAIT)[*2] ##1 state_q == csw_pkg::ST_DONE)  // R11 R13
    else $error("write wait wrong for count one extra one");
  AST_LEVEL_WRITE: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_wr && i_addr == 4'h3 |=> level_q[3] == $past(i_wdata[1]))             // R1
    else $error("level bit not taken from write");
  AST_ENABLED_IDLE_HIGH: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ($past(enable_q[2]) && !$past(sel_q[2])) |-> o_select_n[2])             // R6
    else $error("enabled line pin follows level bit");
endmodule

//--- inc/csw_pkg.sv
package csw_pkg;
  localparam int          NUM_LINES      = 6;
  localparam int          BOOT_LINE      = 0;
  localparam logic [3:0]  ADDR_W         = 4'h4;
  // Register index = line number; one control register per select line
  localparam logic [3:0]  OFS_CTRL_BASE  = 4'h0;
  localparam logic [3:0]  OFS_STATUS     = 4'h8;
  // Control register field positions
  localparam int          POS_ENABLE     = 0;
  localparam int          POS_LEVEL      = 1;
  localparam int          POS_WSC_LO     = 8;
  localparam int          POS_WSC_HI     = 13;
  localparam int          POS_WWS_LO     = 16;
  localparam int          POS_WWS_HI     = 18;
  // Reset values
  localparam logic        RST_EN_BOOT    = 1'b1;
  localparam logic        RST_EN_OTHER   = 1'b0;
  localparam logic        RST_LVL_OTHER  = 1'b1;
  localparam logic [5:0]  RST_WSC        = 6'h00;
  localparam logic [2:0]  RST_WWS        = 3'h0;
  localparam logic [5:0]  WSC_RESERVED   = 6'h3f;
  localparam logic [6:0]  WAIT_MAX       = 7'h3f;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} csw_state_t;
endpackage

//--- verification/csw_mem_model.sv
`timescale 1ns/1ns
// Stands for the memories on the select lines; it measures how long each select is held low
module csw_mem_model (
  input  wire logic             i_clock,    // System clock
  input  wire logic             i_resetn,   // Async reset, active low
  input  wire logic [5:0]       i_select_n, // Select pins from the block
  output logic      [5:0][7:0]  o_width     // Low time of the last select, in cycles
);
  logic [5:0][7:0] cnt_q;

  // The width is latched on the rising edge of the pin so a running count never shows mid-access
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q   <= '0;
      o_width <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (i_select_n[i] === 1'b0) begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end else if (cnt_q[i] != 8'h00) begin
          o_width[i] <= cnt_q[i];
          cnt_q[i]   <= 8'h00;
        end
      end
    end
  end
endmodule

//--- verification/csw_select_tb.sv
`timescale 1ns/1ns
module csw_select_tb;
  logic            i_clock = 1'b0;
  logic            i_resetn = 1'b0;
  logic [3:0]      i_addr = 4'h0;
  logic [31:0]     i_wdata = 32'h0;
  logic            i_wr = 1'b0;
  logic            i_rd = 1'b0;
  logic            i_acc_valid = 1'b0;
  logic [2:0]      i_acc_line = 3'h0;
  logic            i_acc_write = 1'b0;
  logic [31:0]     o_rdata;
  logic            o_acc_done;
  logic            o_acc_error;
  logic            o_busy;
  logic [5:0]      o_select_n;
  logic [5:0][7:0] width;
  int              bad_count = 0;
  int              n_tests = 0;
  logic [31:0]     d;
  logic [5:0]      cw [7] = '{6'h00, 6'h00, 6'h01, 6'h00, 6'h3e, 6'h3e, 6'h05};
  logic [2:0]      cx [7] = '{3'h0, 3'h1, 3'h1, 3'h7, 3'h7, 3'h1, 3'h0};
  logic [2:0]      ln;
  logic [5:0]      wait_count_field;
  logic [2:0]      write_extra_wait_field;
  logic            wb;

  csw_select dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
                  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_acc_valid(i_acc_valid),
                  .i_acc_line(i_acc_line), .i_acc_write(i_acc_write), .o_acc_done(o_acc_done),
                  .o_acc_error(o_acc_error), .o_busy(o_busy), .o_select_n(o_select_n));
  csw_mem_model mem (.i_clock(i_clock), .i_resetn(i_resetn), .i_select_n(o_select_n), .o_width(width));

  always #25 i_clock = ~i_clock;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Every bus task starts on a fresh edge so no strobe is assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    v = o_rdata;
  endtask

  task automatic cfg(input logic [2:0] l, input logic en, input logic lv, input logic [5:0] c, input logic [2:0] x);
    wr({1'b0, l}, {13'h0, x, 2'h0, c, 6'h0, lv, en});
  endtask

  function automatic logic [6:0] exp_wait(input logic [5:0] c, input logic [2:0] x, input logic w);
    int s;
    s = (c == 6'h00) ? 1 : int'(c);
    if (w && x != 3'h0)
      s = (c == 6'h00) ? int'(x) : int'(c) + int'(x);
    if (s > 63)
      s = 63;
    return 7'(s);
  endfunction

  task automatic acc(input logic [2:0] l, input logic w, input logic err, input logic [6:0] ws);
    int   n;
    logic low;
    n = 0;
    low = 1'b0;
    @(posedge i_clock);
    i_acc_valid <= 1'b1; i_acc_line <= l; i_acc_write <= w;
    @(posedge i_clock);
    i_acc_valid <= 1'b0;
    do begin
      @(negedge i_clock);
      n++;
      if (l < 3'h6 && o_select_n[l] === 1'b0)
        low = 1'b1;
    end while (o_acc_done !== 1'b1 && o_acc_error !== 1'b1 && n < 200);
    if (n >= 200) begin
      bad_count++;
      close_out();
    end else begin
      check({31'h0, o_acc_error}, {31'h0, err});
      check(32'(n), err ? 32'h1 : 32'(ws) + 32'h2);
      check({31'h0, low}, {31'h0, ~err});
      if (!err) begin
        repeat (2) @(negedge i_clock);
        check({24'h0, width[l]}, 32'(ws) + 32'h1);
      end
    end
  endtask

  initial begin
    void'($urandom(25665));
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(4'(i), d);
      check(d, (i == 0) ? 32'h1 : 32'h2);
    end
    wr(4'h0, 32'h3);
    rd(4'h0, d);
    check(d, 32'h1);
    wr(4'h9, 32'hffff_ffff);
    rd(4'h9, d);
    check(d, 32'h0);
    for (int i = 1; i < 6; i++) begin
      for (int v = 0; v < 2; v++) begin
        cfg(3'(i), 1'b0, 1'(v), 6'h00, 3'h0);
        repeat (2) @(posedge i_clock);
        check({31'h0, o_select_n[i]}, 32'(v));
      end
    end
    acc(3'h3, 1'b1, 1'b1, 7'h0);
    acc(3'h6, 1'b0, 1'b1, 7'h0);
    rd(4'h8, d);
    check(d & 32'h10, 32'h10);
    cfg(3'h2, 1'b1, 1'b0, 6'h02, 3'h0);
    repeat (2) @(posedge i_clock);
    check({31'h0, o_select_n[2]}, 32'h1);
    acc(3'h2, 1'b0, 1'b0, 7'h2);
    cfg(3'h0, 1'b0, 1'b0, 6'h00, 3'h0);
    acc(3'h0, 1'b0, 1'b1, 7'h0);
    check({31'h0, o_select_n[0]}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      cfg(3'h1, 1'b1, 1'b1, cw[i], cx[i]);
      acc(3'h1, i != 0, 1'b0, exp_wait(cw[i], cx[i], i != 0));
    end
    for (int k = 0; k < 20; k++) begin
      ln = 3'($urandom_range(0, 5));
      wait_count_field = 6'($urandom_range(0, 62));
      write_extra_wait_field = 3'($urandom_range(0, 7));
      wb = 1'($urandom_range(0, 1));
      cfg(ln, 1'b1, 1'b1, wait_count_field, write_extra_wait_field);
      acc(ln, wb, 1'b0, exp_wait(wait_count_field, write_extra_wait_field, wb));
    end
    close_out();
  end
endmodule
